//--- rtl/ietc_pkg.sv
package ietc_pkg;
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned NUM_CHAN = 8;
    localparam logic [3:0] LVL_TOP = 4'hF;
    localparam logic [3:0] LVL_HIGH = 4'hE;
    localparam logic [2:0] CHAN_HIGH_MIN = 3'h4;
    localparam logic [15:0] SEG_ZERO = 16'h0000;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    // status word field layout
    localparam int unsigned STW_LVL_LSB = 12;
    localparam int unsigned STW_ARITH_BIT = 7;
    // page limit of the transfer space: pages 0..3 of segment 0
    localparam logic [17:0] XFER_LIMIT = 18'h0FFFF;
    localparam logic [15:0] INC_BYTE = 16'h0001;
    localparam logic [15:0] INC_WORD = 16'h0002;
    // pointer update mode of a channel
    localparam logic [1:0] INC_NONE = 2'h0;
    localparam logic [1:0] INC_DST = 2'h1;
    localparam logic [1:0] INC_SRC = 2'h2;
    localparam int unsigned RESUME_CYCLES = 2;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned STACK_W = 16;
endpackage

//--- rtl/ietc_stack_if.sv
`timescale 1ns/10ps
interface ietc_stack_if;
    logic valid;
    logic ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- rtl/ietc_fifo.sv
`timescale 1ns/10ps
module ietc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    ietc_stack_if.snk wr,
    ietc_stack_if.src rd
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic doWr;
    logic doRd;

    assign wr.ready = count_ff < (AW+1)'(DEPTH);
    assign rd.valid = count_ff != '0;
    assign rd.data = mem_ff[rdPtr_ff];
    assign doWr = wr.valid && wr.ready;
    assign doRd = rd.valid && rd.ready;

    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem_ff[wrPtr_ff] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doWr) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule // ietc_fifo

//--- rtl/ietc_core.sv
`timescale 1ns/10ps
//
// Overview of operation
// - segmented entry pushes status, segment, pointer
// - flat entry pushes status then pointer
// - segmented entry loads segment zero
// - copy winner level, clear its flag
// - set arithmetic flag if multiply busy
// - entry leaves data page pointers alone
// - return pops in reverse order
// - context switch pushes old, loads new
// - transfers stay within segment zero pages
// - transfer leaves pointer and flags untouched
// - event service outranks cpu interrupts
// - level 14 high channels, 15 none
// - one transfer, width from channel bit
// - optional pointer increment, counter decrement
// - zero counter raises normal interrupt
// - simultaneous requests on one channel give one transfer
// - compete, trap next cycle, fetch after
// - pipeline finishes; trap stacks in two cycles
// - response about three instruction cycles
// - holds and status writes lengthen response
// - two resumed cycles before next entry
// - event response two instruction cycles
//
module ietc_core
    import ietc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cycleStart,
    input wire logic pipeHold,
    input wire logic [NUM_SRC-1:0] reqSet,
    input wire logic [NUM_SRC*4-1:0] srcLevel,
    input wire logic [NUM_SRC-1:0] srcIsEvent,
    input wire logic [NUM_SRC*3-1:0] srcChan,
    input wire logic segEnable,
    input wire logic arithBusy,
    input wire logic [15:0] statusWordIn,
    input wire logic [15:0] instrPointerIn,
    input wire logic [15:0] codeSegmentIn,
    input wire logic retIntExec,
    input wire logic [15:0] popData,
    input wire logic ctxSwExec,
    input wire logic [15:0] ctxSwImm,
    input wire logic [15:0] chanSrcPtr,
    input wire logic [15:0] chanDstPtr,
    input wire logic [7:0] chanCount,
    input wire logic chanByteWidth,
    input wire logic [1:0] chanIncMode,
    input wire logic stackReady,
    output logic stackPushValid,
    output logic [15:0] stackPushData,
    output logic stackPop,
    output logic trapActive,
    output logic [2:0] trapSource,
    output logic vectorFetch,
    output logic [15:0] statusWordOut,
    output logic [15:0] codeSegmentOut,
    output logic [15:0] instrPointerOut,
    output logic restoreValid,
    output logic [15:0] contextPointer,
    output logic xferStart,
    output logic [2:0] xferChan,
    output logic xferByte,
    output logic [17:0] xferSrcAddr,
    output logic [17:0] xferDstAddr,
    output logic chanUpdate,
    output logic [15:0] nxtChanSrc,
    output logic [15:0] nxtChanDst,
    output logic [7:0] nxtChanCount,
    output logic [NUM_SRC-1:0] reqFlags
);
    typedef enum logic [2:0] {
        IDLE, TRAP1, TRAP2, TRAP3, FETCH, POP
    } ietc_state_e;

    ietc_state_e state_ff;
    logic [NUM_SRC-1:0] flags_ff;
    logic [NUM_SRC-1:0] compete_ff;
    logic [2:0] winSrc_ff;
    logic [3:0] winLvl_ff;
    logic [15:0] stWord_ff;
    logic [15:0] codeSeg_ff;
    logic [15:0] instrPtr_ff;
    logic [15:0] ctxPtr_ff;
    logic [1:0] popIdx_ff;
    logic [1:0] resume_ff;
    logic pushValid_ff;
    logic [15:0] pushData_ff;
    logic pop_ff;
    logic trap_ff;
    logic fetch_ff;
    logic restore_ff;
    logic xfer_ff;
    logic [2:0] xChan_ff;
    logic xByte_ff;
    logic [17:0] xSrc_ff;
    logic [17:0] xDst_ff;
    logic upd_ff;
    logic [15:0] uSrc_ff;
    logic [15:0] uDst_ff;
    logic [7:0] uCnt_ff;
    logic [NUM_SRC-1:0] clrMask;
    logic [NUM_SRC-1:0] setMask;

    // stacked words pass a small buffer so a slow stack back-pressures
    ietc_stack_if pushIn();
    ietc_stack_if pushOut();

    ietc_fifo #(.WIDTH(STACK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wr(pushIn),
        .rd(pushOut)
    );

    function automatic logic [3:0] lvlOf(input logic [2:0] s,
                                         input logic [NUM_SRC*4-1:0] v);
        lvlOf = v[s*4 +: 4];
    endfunction

    function automatic logic [2:0] chanOf(input logic [2:0] s,
                                          input logic [NUM_SRC*3-1:0] v);
        chanOf = v[s*3 +: 3];
    endfunction

    // top levels limit channels
    // event channel permitted under the current cpu level
    function automatic logic chanAllowed(input logic [2:0] c,
                                         input logic [3:0] cpuLvl);
        if (cpuLvl == LVL_TOP) begin
            chanAllowed = 1'b0;
        end else if (cpuLvl == LVL_HIGH) begin
            chanAllowed = c >= CHAN_HIGH_MIN;
        end else begin
            chanAllowed = 1'b1;
        end
    endfunction

    // ------------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------------
    logic winFound;
    logic winEvent;
    logic [2:0] winSrc;
    logic [3:0] winLvl;
    logic [3:0] cpuLvl;

    assign cpuLvl = stWord_ff[STW_LVL_LSB +: 4];

    always_comb begin
        logic [4:0] best;
        logic [4:0] key;
        logic ev;
        best = '0;
        key = '0;
        ev = 1'b0;
        winFound = 1'b0;
        winEvent = 1'b0;
        winSrc = '0;
        winLvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            ev = srcIsEvent[i] && chanAllowed(chanOf(3'(i), srcChan),
                                              cpuLvl);
            key = {ev, lvlOf(3'(i), srcLevel)};
            if (compete_ff[i] && (ev || lvlOf(3'(i), srcLevel) > cpuLvl)
                && (!winFound || key > best)) begin
                best = key;
                winFound = 1'b1;
                winEvent = ev;
                winSrc = 3'(i);
                winLvl = lvlOf(3'(i), srcLevel);
            end
        end
    end

    logic cpuGo;
    logic evGo;
    logic evMove;
    logic [NUM_SRC-1:0] sameChan;

    // spent channel is served as a cpu entry
    assign evMove = winEvent && chanCount != CNT_ZERO;
    assign cpuGo = cycleStart && !pipeHold && state_ff == IDLE && winFound
        && !evMove && resume_ff == '0;
    assign evGo = cycleStart && !pipeHold && winFound && evMove
        && state_ff == IDLE;

    always_comb begin
        sameChan = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            sameChan[i] = compete_ff[i] && srcIsEvent[i]
                && chanOf(3'(i), srcChan) == chanOf(winSrc, srcChan);
        end
    end

    always_comb begin
        clrMask = '0;
        if (evGo) begin
            clrMask = sameChan;
        end else if (cpuGo) begin
            clrMask[winSrc] = 1'b1;
        end
    end

    assign setMask = reqSet;

    // ------------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------------
    // winner flag cleared, set wins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (flags_ff & ~clrMask) | setMask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            compete_ff <= '0;
        end else if (cycleStart && !pipeHold) begin
            compete_ff <= flags_ff & ~clrMask;
        end else begin
            compete_ff <= compete_ff & ~clrMask;
        end
    end

    // ------------------------------------------------------------------
    // entry and return sequence
    // ------------------------------------------------------------------
    logic pushFire;
    assign pushFire = pushIn.valid && pushIn.ready;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= IDLE;
            winSrc_ff <= '0;
            winLvl_ff <= '0;
            stWord_ff <= '0;
            codeSeg_ff <= '0;
            instrPtr_ff <= '0;
            popIdx_ff <= '0;
            pop_ff <= 1'b0;
            trap_ff <= 1'b0;
            fetch_ff <= 1'b0;
            restore_ff <= 1'b0;
        end else begin
            pop_ff <= 1'b0;
            fetch_ff <= 1'b0;
            restore_ff <= 1'b0;
            case (state_ff)
                IDLE: begin
                    trap_ff <= 1'b0;
                    stWord_ff <= statusWordIn;
                    codeSeg_ff <= codeSegmentIn;
                    instrPtr_ff <= instrPointerIn;
                    if (cpuGo) begin
                        state_ff <= TRAP1;
                        trap_ff <= 1'b1;
                        winSrc_ff <= winSrc;
                        winLvl_ff <= winLvl;
                    end else if (retIntExec) begin
                        state_ff <= POP;
                        popIdx_ff <= segEnable ? 2'h2 : 2'h1;
                        pop_ff <= 1'b1;
                    end
                end
                TRAP1: if (pushFire) begin
                    state_ff <= segEnable ? TRAP2 : TRAP3;
                end
                TRAP2: if (pushFire) begin
                    state_ff <= TRAP3;
                end
                TRAP3: if (pushFire) begin
                    state_ff <= FETCH;
                end
                FETCH: begin
                    stWord_ff[STW_LVL_LSB +: 4] <= winLvl_ff;
                    stWord_ff[STW_ARITH_BIT] <= arithBusy;
                    if (segEnable) begin
                        codeSeg_ff <= SEG_ZERO;
                    end
                    fetch_ff <= 1'b1;
                    trap_ff <= 1'b0;
                    state_ff <= IDLE;
                end
                POP: begin
                    if (popIdx_ff == 2'h0) begin
                        stWord_ff <= popData;
                        restore_ff <= 1'b1;
                        state_ff <= IDLE;
                    end else begin
                        if (popIdx_ff == 2'h2) begin
                            instrPtr_ff <= popData;
                        end else if (segEnable) begin
                            codeSeg_ff <= popData;
                        end else begin
                            instrPtr_ff <= popData;
                        end
                        pop_ff <= 1'b1;
                        popIdx_ff <= popIdx_ff - 2'h1;
                    end
                end
                default: state_ff <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resume_ff <= '0;
        end else if (restore_ff) begin
            resume_ff <= 2'(RESUME_CYCLES);
        end else if (cycleStart && !pipeHold && resume_ff != '0) begin
            resume_ff <= resume_ff - 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // stack push path
    // ------------------------------------------------------------------
    always_comb begin
        pushIn.valid = 1'b0;
        pushIn.data = '0;
        case (state_ff)
            TRAP1: begin
                pushIn.valid = 1'b1;
                pushIn.data = stWord_ff;
            end
            TRAP2: begin
                pushIn.valid = 1'b1;
                pushIn.data = codeSeg_ff;
            end
            TRAP3: begin
                pushIn.valid = 1'b1;
                pushIn.data = instrPtr_ff;
            end
            default: begin
                pushIn.valid = ctxSwExec;
                pushIn.data = ctxPtr_ff;
            end
        endcase
    end

    assign pushOut.ready = stackReady || !pushValid_ff;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pushValid_ff <= 1'b0;
            pushData_ff <= '0;
        end else if (pushOut.ready) begin
            pushValid_ff <= pushOut.valid;
            pushData_ff <= pushOut.data;
        end
    end

    // load new bank; no page pointers here
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctxPtr_ff <= '0;
        end else if (ctxSwExec && state_ff == IDLE && pushFire) begin
            ctxPtr_ff <= ctxSwImm;
        end
    end

    // ------------------------------------------------------------------
    // event transfer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xfer_ff <= 1'b0;
            xChan_ff <= '0;
            xByte_ff <= 1'b0;
            xSrc_ff <= '0;
            xDst_ff <= '0;
            upd_ff <= 1'b0;
            uSrc_ff <= '0;
            uDst_ff <= '0;
            uCnt_ff <= '0;
        end else begin
            xfer_ff <= evGo && chanCount != CNT_ZERO;
            upd_ff <= evGo && chanCount != CNT_ZERO;
            if (evGo) begin
                xChan_ff <= chanOf(winSrc, srcChan);
                xByte_ff <= chanByteWidth;
                xSrc_ff <= {2'h0, chanSrcPtr} & XFER_LIMIT;
                xDst_ff <= {2'h0, chanDstPtr} & XFER_LIMIT;
                uSrc_ff <= chanIncMode == INC_SRC ? chanSrcPtr
                    + (chanByteWidth ? INC_BYTE : INC_WORD) : chanSrcPtr;
                uDst_ff <= chanIncMode == INC_DST ? chanDstPtr
                    + (chanByteWidth ? INC_BYTE : INC_WORD) : chanDstPtr;
                uCnt_ff <= chanCount - CNT_ONE;
            end
        end
    end

    assign stackPushValid = pushValid_ff;
    assign stackPushData = pushData_ff;
    assign stackPop = pop_ff;
    assign trapActive = trap_ff;
    assign trapSource = winSrc_ff;
    assign vectorFetch = fetch_ff;
    assign statusWordOut = stWord_ff;
    assign codeSegmentOut = codeSeg_ff;
    assign instrPointerOut = instrPtr_ff;
    assign restoreValid = restore_ff;
    assign contextPointer = ctxPtr_ff;
    assign xferStart = xfer_ff;
    assign xferChan = xChan_ff;
    assign xferByte = xByte_ff;
    assign xferSrcAddr = xSrc_ff;
    assign xferDstAddr = xDst_ff;
    assign chanUpdate = upd_ff;
    assign nxtChanSrc = uSrc_ff;
    assign nxtChanDst = uDst_ff;
    assign nxtChanCount = uCnt_ff;
    assign reqFlags = flags_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_seg_order;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_ff == TRAP1 && pushFire && segEnable) |=> state_ff == TRAP2;
    endproperty
    a_seg_order: assert property (p_seg_order)
        else $error("segment not pushed after status");

    property p_flat_order;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_ff == TRAP1 && pushFire && !segEnable) |=> state_ff == TRAP3;
    endproperty
    a_flat_order: assert property (p_flat_order)
        else $error("flat entry pushed segment");

    property p_seg_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        (state_ff == FETCH && segEnable) |=> codeSeg_ff == SEG_ZERO;
    endproperty
    a_seg_zero: assert property (p_seg_zero)
        else $error("segment not zero on entry");

    property p_level;
        @(posedge clk_sys) disable iff (!rst_b)
        state_ff == FETCH |=> stWord_ff[STW_LVL_LSB +: 4] == $past(winLvl_ff);
    endproperty
    a_level: assert property (p_level)
        else $error("level not copied");

    property p_level15;
        @(posedge clk_sys) disable iff (!rst_b)
        cpuLvl == LVL_TOP |-> !evGo;
    endproperty
    a_level15: assert property (p_level15)
        else $error("transfer at top level");

    property p_xfer;
        @(posedge clk_sys) disable iff (!rst_b)
        (evGo && chanCount != CNT_ZERO) |=> xferStart && chanUpdate;
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("transfer not started");

    property p_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        (cpuGo && winEvent) |=> trapActive && !xferStart;
    endproperty
    a_zero: assert property (p_zero)
        else $error("transfer at zero count");

    property p_atomic;
        @(posedge clk_sys) disable iff (!rst_b)
        state_ff == TRAP1 |-> !cpuGo;
    endproperty
    a_atomic: assert property (p_atomic)
        else $error("entry during stacking");

    c_entry: cover property (@(posedge clk_sys) disable iff (!rst_b)
        vectorFetch);
    c_xfer: cover property (@(posedge clk_sys) disable iff (!rst_b)
        xferStart);
    c_ret: cover property (@(posedge clk_sys) disable iff (!rst_b)
        restoreValid);
endmodule // ietc_core

//--- verification/ietc_cpu_model.sv
`timescale 1ns/10ps
module ietc_cpu_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic stackPushValid,
    input wire logic [15:0] stackPushData,
    input wire logic stackPop,
    output logic stackReady,
    output logic [15:0] popData,
    output logic cycleStart
);
    logic [15:0] stk [0:15];
    int sp;
    logic phase_ff;

    // ------------------------------------------------
    // system stack
    // ------------------------------------------------
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sp <= 0;
        end else if (stackPushValid && stackReady) begin
            stk[4'(sp)] <= stackPushData;
            sp <= sp + 1;
        end else if (stackPop && sp > 0) begin
            sp <= sp - 1;
        end
    end

    // no stale word between pops, so a late sample is caught
    assign popData = stackPop ? stk[4'(sp - 1)] : 16'h5A5A ^ {16{phase_ff}};

    // two-clock instruction cycles; stall halves stack acceptance
    always @(negedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= 1'b0;
            cycleStart <= 1'b0;
            stackReady <= 1'b0;
        end else begin
            phase_ff <= !phase_ff;
            cycleStart <= !phase_ff;
            stackReady <= !stall || phase_ff;
        end
    end
endmodule // ietc_cpu_model

//--- verification/interrupt_entry_and_event_transfer_bench.sv
`timescale 1ns/10ps
module interrupt_entry_and_event_transfer_bench;
    import ietc_pkg::*;
    logic clk_sys, rst_b, cycleStart, pipeHold, segEnable, arithBusy;
    logic retIntExec, ctxSwExec, chanByteWidth, stackReady, stall, stackPop;
    logic stackPushValid, trapActive, vectorFetch, restoreValid, xferStart;
    logic xferByte, chanUpdate;
    logic [7:0] reqSet, srcIsEvent, reqFlags, chanCount, nxtChanCount;
    logic [31:0] srcLevel;
    logic [23:0] srcChan;
    logic [15:0] statusWordIn, instrPointerIn, codeSegmentIn, popData;
    logic [15:0] ctxSwImm, chanSrcPtr, chanDstPtr, stackPushData;
    logic [15:0] statusWordOut, codeSegmentOut, instrPointerOut;
    logic [15:0] contextPointer, nxtChanSrc, nxtChanDst;
    logic [1:0] chanIncMode;
    logic [2:0] trapSource, xferChan;
    logic [17:0] xferSrcAddr, xferDstAddr;
    int mismatches, samples_checked, n, base, hits;

    ietc_core u_ietc_core (.clk_sys, .rst_b, .cycleStart, .pipeHold,
        .reqSet, .srcLevel, .srcIsEvent, .srcChan, .segEnable, .arithBusy,
        .statusWordIn, .instrPointerIn, .codeSegmentIn, .retIntExec, .popData,
        .ctxSwExec, .ctxSwImm, .chanSrcPtr, .chanDstPtr, .chanCount,
        .chanByteWidth, .chanIncMode, .stackReady, .stackPushValid,
        .stackPushData, .stackPop, .trapActive, .trapSource, .vectorFetch,
        .statusWordOut, .codeSegmentOut, .instrPointerOut, .restoreValid,
        .contextPointer, .xferStart, .xferChan, .xferByte, .xferSrcAddr,
        .xferDstAddr, .chanUpdate, .nxtChanSrc, .nxtChanDst, .nxtChanCount,
        .reqFlags);
    ietc_cpu_model u_ietc_cpu_model (.clk_sys, .rst_b, .stall,
        .stackPushValid, .stackPushData, .stackPop, .stackReady, .popData,
        .cycleStart);

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] stk(int i);
        return u_ietc_cpu_model.stk[i];
    endfunction

    function automatic logic [17:0] depth();
        return 18'(u_ietc_cpu_model.sp - base);
    endfunction

    task automatic raise(logic [7:0] bits);
        reqSet = bits;
        @(negedge clk_sys);
        reqSet = 8'h00;
    endtask

    task automatic count_moves(int cycles);
        hits = 0;
        repeat (cycles) begin
            @(negedge clk_sys);
            hits += int'(xferStart === 1'b1);
        end
    endtask

    // full trap and return, stack contents compared word by word
    task automatic entry(logic seg, logic [2:0] src);
        logic [15:0] oldSt, oldPtr, oldSeg;
        oldSt = statusWordIn;
        oldPtr = instrPointerIn;
        oldSeg = codeSegmentIn;
        base = u_ietc_cpu_model.sp;
        segEnable = seg;
        hits = 0;
        raise(8'h01 << src);
        for (n = 0; n < 60 && vectorFetch !== 1'b1; n++) begin
            hits += int'(xferStart === 1'b1);
            @(negedge clk_sys);
        end
        check("vector fetch", vectorFetch, 1'b1);
        check("trap source", trapSource, src);
        check("event moves", 18'(hits), 18'h0);
        check("new level", statusWordOut[15:12], srcLevel[src*4+:4]);
        check("arith", statusWordOut[STW_ARITH_BIT], arithBusy);
        check("req flag", reqFlags[src], 1'b0);
        if (seg) check("isr seg", codeSegmentOut, SEG_ZERO);
        repeat (8) @(negedge clk_sys);
        check("pushes", depth(), seg ? 18'h3 : 18'h2);
        check("stacked status", stk(base), oldSt);
        if (seg) check("stacked seg", stk(base + 1), oldSeg);
        check("stacked pointer", stk(base + 1 + seg), oldPtr);
        // new inputs, so the return must show the stacked words
        statusWordIn = ~oldSt;
        instrPointerIn = ~oldPtr;
        codeSegmentIn = ~oldSeg;
        retIntExec = 1'b1;
        @(negedge clk_sys);
        retIntExec = 1'b0;
        for (n = 0; n < 60 && restoreValid !== 1'b1; n++) @(negedge clk_sys);
        check("restored", restoreValid, 1'b1);
        check("ret pointer", instrPointerOut, oldPtr);
        check("ret status", statusWordOut, oldSt);
        if (seg) check("ret seg", codeSegmentOut, oldSeg);
        statusWordIn = oldSt;
        instrPointerIn = oldPtr;
        codeSegmentIn = oldSeg;
        repeat (4) @(negedge clk_sys);
        check("stack back", depth(), 18'h0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        {pipeHold, segEnable, arithBusy, retIntExec, ctxSwExec} = 5'h00;
        {stall, chanByteWidth, rst_b} = 3'h0;
        {reqSet, srcIsEvent, chanCount, srcChan, chanIncMode} = 50'h0;
        {ctxSwImm, chanSrcPtr, chanDstPtr} = 48'h0;
        statusWordIn = 16'h0A42;
        instrPointerIn = 16'h3F1C;
        codeSegmentIn = 16'h0007;
        srcLevel = 32'h000F_F500;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (2) @(negedge clk_sys);
        stall = 1'b1;
        arithBusy = 1'b1;
        entry(1'b1, 3'h2);
        stall = 1'b0;
        arithBusy = 1'b0;
        entry(1'b0, 3'h2);
        base = u_ietc_cpu_model.sp;
        // no bank access right after switch
        ctxSwImm = 16'h5A40;
        ctxSwExec = 1'b1;
        for (n = 0; n < 20 && contextPointer !== 16'h5A40; n++) begin
            @(negedge clk_sys);
        end
        ctxSwExec = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("ctx pointer", contextPointer, 16'h5A40);
        check("ctx pushes", depth(), 18'h1);
        check("old ctx", stk(base), 16'h0000);
        srcIsEvent = 8'h18;
        srcChan = 24'h005A00;
        chanCount = 8'h03;
        chanSrcPtr = 16'h1230;
        chanDstPtr = 16'hFE40;
        for (int k = 0; k < 2; k++) begin
            chanByteWidth = (k == 0);
            chanIncMode = k ? INC_DST : INC_SRC;
            base = u_ietc_cpu_model.sp;
            raise(8'h18);
            for (n = 0; n < 40 && xferStart !== 1'b1; n++) @(negedge clk_sys);
            check("xfer seen", xferStart, 1'b1);
            check("chan", xferChan, 3'h5);
            check("byte", xferByte, chanByteWidth);
            check("src addr", xferSrcAddr, {2'h0, chanSrcPtr});
            check("dst addr", xferDstAddr, {2'h0, chanDstPtr});
            for (n = 0; n < 10 && chanUpdate !== 1'b1; n++) @(negedge clk_sys);
            check("next src", nxtChanSrc, chanSrcPtr + (k ? 0 : 1));
            check("next dst", nxtChanDst, chanDstPtr + (k ? 2 : 0));
            check("next count", nxtChanCount, 8'h02);
            count_moves(20);
            check("extra moves", 18'(hits), 18'h0);
            check("no stacking", depth(), 18'h0);
            check("pointer kept", instrPointerOut, instrPointerIn);
        end
        chanCount = CNT_ZERO;
        srcIsEvent = 8'h08;
        entry(1'b0, 3'h3);
        chanCount = 8'h03;
        for (int k = 0; k < 3; k++) begin
            statusWordIn[15:12] = k ? LVL_HIGH : LVL_TOP;
            srcChan[9+:3] = (k == 1) ? 3'h2 : 3'h6;
            raise(8'h08);
            count_moves(30);
            check("gate", 18'(hits), (k == 2) ? 18'h1 : 18'h0);
        end
        print_verdict();
    end
endmodule // interrupt_entry_and_event_transfer_bench
